// [design/sixteen_bit_load_group.sv]
// Sequencer executing the 16-bit load group of a byte-wide processor core.
// Assumes memory answers combinationally on the same clock: read data is valid
// in the last T state of each read cycle, and a write is taken while memWrite is high.
//
// How it works
// - Pair field 00,01,10,11 selects first pair, second pair, pointer pair, stack pointer.
// - Immediate word to a pair; 10 T states as 4, 3, 3.
// - Prefix DD then 21 loads first index immediately; 14 T states as 4,4,3,3.
// - Second index immediate load takes the operand; 14 T states as 4,4,3,3.
// - Opcode 2A loads pointer pair low then high from direct address; 16 T states.
// - Second index loads low from address, high from address plus one; 20 T.
// - Opcode 22 stores pointer pair low then high at next address; 20 T states.
// - Selected pair stored low at address, high at address plus one; 20 T.
// - First index stored low at address, high at next address; 20 T states.
// - Second index stored low at address, high at following address; 20 T.
// - Opcode F9 copies pointer pair into stack pointer, pointer pair unchanged.
// - No instruction here changes the flags.
// - First operand byte after opcode is low byte, second is high byte.
`timescale 1ns/1ns
module sixteen_bit_load_group (
  input  wire logic        clock,
  input  wire logic        resetn,
  output logic      [15:0] memAddr,
  output logic             memRead,
  output logic             memWrite,
  output logic      [7:0]  memWrData,
  input  wire logic [7:0]  memRdData,
  output logic             instrDone,
  output logic      [15:0] firstGeneralPair,
  output logic      [15:0] secondGeneralPair,
  output logic      [15:0] pointerPair,
  output logic      [15:0] stackPointer,
  output logic      [15:0] indexRegisterFirst,
  output logic      [15:0] indexRegisterSecond,
  output logic      [15:0] programCounter,
  output logic      [7:0]  flags
);

  sixteen_bit_load_pkg::cycle_t state_r, stateNxt;
  sixteen_bit_load_pkg::kind_t  kind_r, kindNxt;
  logic [2:0]  tCnt_r;
  logic [15:0] pc_r, pcNxt;
  logic [15:0] addr_r, addrNxt;
  logic [7:0]  tmpLo_r, tmpLoNxt;
  logic [2:0]  sel_r, selNxt;
  logic        prefIdx_r, prefIdxNxt;
  logic        prefExt_r, prefExtNxt;
  logic [15:0] regFile [sixteen_bit_load_pkg::NUM_REGS];
  logic [7:0]  flags_r;
  logic [15:0] memAddr_r, busAddrNxt;
  logic        memRead_r, busRdNxt;
  logic        memWrite_r, busWrNxt;
  logic [7:0]  memWrData_r, busDataNxt;
  logic        regWe;
  logic [2:0]  regWeIdx;
  logic [15:0] regWeData;
  logic [2:0]  cycLen;
  logic        cycEnd;
  logic [1:0]  pairField;
  logic [15:0] operandWord;
  logic [15:0] srcWord;
  logic [15:0] srcWordNxt;
  logic        memOperandNxt;

  function automatic logic [2:0] pairIndex(input logic [1:0] field);
    case (field)
      2'h0:    pairIndex = sixteen_bit_load_pkg::REG_FIRST_GENERAL;
      2'h1:    pairIndex = sixteen_bit_load_pkg::REG_SECOND_GENERAL;
      2'h2:    pairIndex = sixteen_bit_load_pkg::REG_POINTER;
      default: pairIndex = sixteen_bit_load_pkg::REG_STACK;
    endcase
  endfunction

  function automatic logic [2:0] cycleLen(input sixteen_bit_load_pkg::cycle_t st);
    case (st)
      sixteen_bit_load_pkg::S_FETCH,
      sixteen_bit_load_pkg::S_FETCH2:   cycleLen = sixteen_bit_load_pkg::T_FETCH;
      sixteen_bit_load_pkg::S_INTERNAL: cycleLen = sixteen_bit_load_pkg::T_INTERNAL;
      sixteen_bit_load_pkg::S_SPCOPY:   cycleLen = sixteen_bit_load_pkg::T_SP_COPY;
      default:                          cycleLen = sixteen_bit_load_pkg::T_MEM;
    endcase
  endfunction

  assign cycLen      = cycleLen(state_r);
  assign cycEnd      = (tCnt_r == cycLen - 3'h1);
  assign pairField   = memRdData[sixteen_bit_load_pkg::PAIR_FIELD_MSB:sixteen_bit_load_pkg::PAIR_FIELD_LSB];
  assign operandWord = {memRdData, tmpLo_r};
  assign srcWord     = regFile[sel_r];
  assign srcWordNxt  = regFile[selNxt];
  assign instrDone   = cycEnd && (stateNxt == sixteen_bit_load_pkg::S_FETCH);

  always_comb begin
    stateNxt   = state_r;
    kindNxt    = kind_r;
    pcNxt      = pc_r;
    addrNxt    = addr_r;
    tmpLoNxt   = tmpLo_r;
    selNxt     = sel_r;
    prefIdxNxt = prefIdx_r;
    prefExtNxt = prefExt_r;
    regWe      = 1'b0;
    regWeIdx   = sel_r;
    regWeData  = operandWord;
    if (cycEnd) begin
      case (state_r)
        sixteen_bit_load_pkg::S_FETCH: begin
          pcNxt      = pc_r + 16'h1;
          kindNxt    = sixteen_bit_load_pkg::K_NONE;
          prefIdxNxt = 1'b0;
          prefExtNxt = 1'b0;
          stateNxt   = sixteen_bit_load_pkg::S_FETCH;
          if (memRdData == sixteen_bit_load_pkg::OP_PREFIX_IDX1 ||
              memRdData == sixteen_bit_load_pkg::OP_PREFIX_IDX2) begin
            prefIdxNxt = 1'b1;
            selNxt     = (memRdData == sixteen_bit_load_pkg::OP_PREFIX_IDX2) ?
                         sixteen_bit_load_pkg::REG_INDEX_SECOND :
                         sixteen_bit_load_pkg::REG_INDEX_FIRST;
            stateNxt   = sixteen_bit_load_pkg::S_FETCH2;
          end else if (memRdData == sixteen_bit_load_pkg::OP_PREFIX_EXT) begin
            prefExtNxt = 1'b1;
            stateNxt   = sixteen_bit_load_pkg::S_FETCH2;
          end else if ((memRdData & sixteen_bit_load_pkg::MASK_PAIR_OP) == sixteen_bit_load_pkg::OP_IMM_PAIR) begin
            kindNxt  = sixteen_bit_load_pkg::K_IMM;
            selNxt   = pairIndex(pairField);
            stateNxt = sixteen_bit_load_pkg::S_RDLO;
          end else if (memRdData == sixteen_bit_load_pkg::OP_LOAD_PTR) begin
            kindNxt  = sixteen_bit_load_pkg::K_LDMEM;
            selNxt   = sixteen_bit_load_pkg::REG_POINTER;
            stateNxt = sixteen_bit_load_pkg::S_RDLO;
          end else if (memRdData == sixteen_bit_load_pkg::OP_STORE_PTR) begin
            kindNxt  = sixteen_bit_load_pkg::K_STMEM;
            selNxt   = sixteen_bit_load_pkg::REG_POINTER;
            stateNxt = sixteen_bit_load_pkg::S_INTERNAL;
          end else if (memRdData == sixteen_bit_load_pkg::OP_SP_FROM_PTR) begin
            kindNxt  = sixteen_bit_load_pkg::K_SPHL;
            stateNxt = sixteen_bit_load_pkg::S_SPCOPY;
          end
        end
        sixteen_bit_load_pkg::S_FETCH2: begin
          // Unknown second bytes retire as no-operation so the stream keeps moving
          pcNxt    = pc_r + 16'h1;
          stateNxt = sixteen_bit_load_pkg::S_RDLO;
          if (prefIdx_r && memRdData == sixteen_bit_load_pkg::OP_IMM_INDEX) begin
            kindNxt = sixteen_bit_load_pkg::K_IMM;
          end else if (prefIdx_r && memRdData == sixteen_bit_load_pkg::OP_LOAD_PTR) begin
            kindNxt = sixteen_bit_load_pkg::K_LDMEM;
          end else if (prefIdx_r && memRdData == sixteen_bit_load_pkg::OP_STORE_PTR) begin
            kindNxt = sixteen_bit_load_pkg::K_STMEM;
          end else if (prefExt_r &&
                       (memRdData & sixteen_bit_load_pkg::MASK_PAIR_OP) == sixteen_bit_load_pkg::OP_STORE_PAIR) begin
            kindNxt = sixteen_bit_load_pkg::K_STMEM;
            selNxt  = pairIndex(pairField);
          end else begin
            stateNxt = sixteen_bit_load_pkg::S_FETCH;
          end
        end
        sixteen_bit_load_pkg::S_INTERNAL: begin
          stateNxt = sixteen_bit_load_pkg::S_RDLO;
        end
        sixteen_bit_load_pkg::S_RDLO: begin
          tmpLoNxt = memRdData;
          pcNxt    = pc_r + 16'h1;
          stateNxt = sixteen_bit_load_pkg::S_RDHI;
        end
        sixteen_bit_load_pkg::S_RDHI: begin
          pcNxt = pc_r + 16'h1;
          if (kind_r == sixteen_bit_load_pkg::K_IMM) begin
            regWe    = 1'b1;
            stateNxt = sixteen_bit_load_pkg::S_FETCH;
          end else begin
            addrNxt  = operandWord;
            stateNxt = (kind_r == sixteen_bit_load_pkg::K_LDMEM) ?
                       sixteen_bit_load_pkg::S_MEMRDLO : sixteen_bit_load_pkg::S_MEMWRLO;
          end
        end
        sixteen_bit_load_pkg::S_MEMRDLO: begin
          tmpLoNxt = memRdData;
          addrNxt  = addr_r + 16'h1;
          stateNxt = sixteen_bit_load_pkg::S_MEMRDHI;
        end
        sixteen_bit_load_pkg::S_MEMRDHI: begin
          regWe    = 1'b1;
          stateNxt = sixteen_bit_load_pkg::S_FETCH;
        end
        sixteen_bit_load_pkg::S_MEMWRLO: begin
          addrNxt  = addr_r + 16'h1;
          stateNxt = sixteen_bit_load_pkg::S_MEMWRHI;
        end
        sixteen_bit_load_pkg::S_MEMWRHI: begin
          stateNxt = sixteen_bit_load_pkg::S_FETCH;
        end
        sixteen_bit_load_pkg::S_SPCOPY: begin
          regWe     = 1'b1;
          regWeIdx  = sixteen_bit_load_pkg::REG_STACK;
          regWeData = regFile[sixteen_bit_load_pkg::REG_POINTER];
          stateNxt  = sixteen_bit_load_pkg::S_FETCH;
        end
        default: begin
          stateNxt = sixteen_bit_load_pkg::S_FETCH;
        end
      endcase
    end
  end

  // Bus outputs are set up one edge ahead so that they come straight from flops
  assign memOperandNxt = (stateNxt == sixteen_bit_load_pkg::S_MEMRDLO) || (stateNxt == sixteen_bit_load_pkg::S_MEMRDHI) ||
                         (stateNxt == sixteen_bit_load_pkg::S_MEMWRLO) || (stateNxt == sixteen_bit_load_pkg::S_MEMWRHI);
  assign busWrNxt      = cycEnd ? ((stateNxt == sixteen_bit_load_pkg::S_MEMWRLO) ||
                                   (stateNxt == sixteen_bit_load_pkg::S_MEMWRHI)) : memWrite_r;
  assign busRdNxt      = cycEnd ? (memOperandNxt ? !busWrNxt :
                                   (stateNxt != sixteen_bit_load_pkg::S_INTERNAL &&
                                    stateNxt != sixteen_bit_load_pkg::S_SPCOPY)) : memRead_r;
  assign busAddrNxt    = cycEnd ? (memOperandNxt ? addrNxt : pcNxt) : memAddr_r;
  assign busDataNxt    = cycEnd ? ((stateNxt == sixteen_bit_load_pkg::S_MEMWRHI) ?
                                   srcWordNxt[15:8] : srcWordNxt[7:0]) : memWrData_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r   <= sixteen_bit_load_pkg::S_FETCH;
      kind_r    <= sixteen_bit_load_pkg::K_NONE;
      tCnt_r    <= 3'h0;
      pc_r      <= sixteen_bit_load_pkg::RESET_PC;
      addr_r    <= sixteen_bit_load_pkg::RESET_WORD;
      tmpLo_r   <= 8'h00;
      sel_r     <= sixteen_bit_load_pkg::REG_FIRST_GENERAL;
      prefIdx_r <= 1'b0;
      prefExt_r <= 1'b0;
    end else begin
      state_r   <= stateNxt;
      kind_r    <= kindNxt;
      tCnt_r    <= cycEnd ? 3'h0 : tCnt_r + 3'h1;
      pc_r      <= pcNxt;
      addr_r    <= addrNxt;
      tmpLo_r   <= tmpLoNxt;
      sel_r     <= selNxt;
      prefIdx_r <= prefIdxNxt;
      prefExt_r <= prefExtNxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      memAddr_r   <= sixteen_bit_load_pkg::RESET_PC;
      memRead_r   <= 1'b1;
      memWrite_r  <= 1'b0;
      memWrData_r <= 8'h00;
    end else begin
      memAddr_r   <= busAddrNxt;
      memRead_r   <= busRdNxt;
      memWrite_r  <= busWrNxt;
      memWrData_r <= busDataNxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < sixteen_bit_load_pkg::NUM_REGS; i++) begin
        regFile[i] <= sixteen_bit_load_pkg::RESET_WORD;
      end
    end else if (regWe) begin
      regFile[regWeIdx] <= regWeData;
    end
  end

  // Flags have no write path in this group at all
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flags_r <= sixteen_bit_load_pkg::RESET_FLAGS;
    end else begin
      flags_r <= flags_r;
    end
  end

  assign memAddr             = memAddr_r;
  assign memRead             = memRead_r;
  assign memWrite            = memWrite_r;
  assign memWrData           = memWrData_r;
  assign firstGeneralPair    = regFile[sixteen_bit_load_pkg::REG_FIRST_GENERAL];
  assign secondGeneralPair   = regFile[sixteen_bit_load_pkg::REG_SECOND_GENERAL];
  assign pointerPair         = regFile[sixteen_bit_load_pkg::REG_POINTER];
  assign stackPointer        = regFile[sixteen_bit_load_pkg::REG_STACK];
  assign indexRegisterFirst  = regFile[sixteen_bit_load_pkg::REG_INDEX_FIRST];
  assign indexRegisterSecond = regFile[sixteen_bit_load_pkg::REG_INDEX_SECOND];
  assign programCounter      = pc_r;
  assign flags               = flags_r;

  // Checking helpers: T states since the instruction began
  logic [4:0] tSince_r;
  logic       opDone;
  // An unprefixed no-op retires in its fetch while kind_r still names the instruction before it
  assign opDone = instrDone && (state_r != sixteen_bit_load_pkg::S_FETCH);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tSince_r <= 5'h00;
    end else begin
      tSince_r <= instrDone ? 5'h00 : tSince_r + 5'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_pair_decode;
    state_r == sixteen_bit_load_pkg::S_FETCH && cycEnd && !prefIdx_r &&
    (memRdData & sixteen_bit_load_pkg::MASK_PAIR_OP) == sixteen_bit_load_pkg::OP_IMM_PAIR
    |=> sel_r == {1'b0, $past(pairField)} && state_r == sixteen_bit_load_pkg::S_RDLO;
  endproperty
  a_pair_decode: assert property (p_pair_decode) else $error("pair field decoded wrongly");

  property p_imm_pair_time;
    opDone && kind_r == sixteen_bit_load_pkg::K_IMM && !prefIdx_r |-> tSince_r == 5'(sixteen_bit_load_pkg::TS_IMM_PAIR - 1);
  endproperty
  a_imm_pair_time: assert property (p_imm_pair_time) else $error("immediate pair load length wrong");

  property p_imm_first_time;
    opDone && kind_r == sixteen_bit_load_pkg::K_IMM && sel_r == sixteen_bit_load_pkg::REG_INDEX_FIRST
    |-> tSince_r == 5'(sixteen_bit_load_pkg::TS_IMM_INDEX - 1);
  endproperty
  a_imm_first_time: assert property (p_imm_first_time) else $error("first index immediate length wrong");

  property p_imm_second_value;
    opDone && kind_r == sixteen_bit_load_pkg::K_IMM && sel_r == sixteen_bit_load_pkg::REG_INDEX_SECOND
    |-> tSince_r == 5'(sixteen_bit_load_pkg::TS_IMM_INDEX - 1) ##1 indexRegisterSecond == $past(operandWord);
  endproperty
  a_imm_second_value: assert property (p_imm_second_value) else $error("second index immediate wrong");

  property p_load_ptr;
    opDone && kind_r == sixteen_bit_load_pkg::K_LDMEM && !prefIdx_r
    |-> tSince_r == 5'(sixteen_bit_load_pkg::TS_LOAD_PTR - 1) ##1 pointerPair == {$past(memRdData), $past(tmpLo_r)};
  endproperty
  a_load_ptr: assert property (p_load_ptr) else $error("pointer pair load wrong");

  property p_load_index_time;
    opDone && kind_r == sixteen_bit_load_pkg::K_LDMEM && prefIdx_r |-> tSince_r == 5'(sixteen_bit_load_pkg::TS_LOAD_INDEX - 1);
  endproperty
  a_load_index_time: assert property (p_load_index_time) else $error("index load length wrong");

  property p_store_time;
    opDone && kind_r == sixteen_bit_load_pkg::K_STMEM |-> tSince_r == 5'(sixteen_bit_load_pkg::TS_STORE - 1);
  endproperty
  a_store_time: assert property (p_store_time) else $error("store length wrong");

  property p_store_order;
    state_r == sixteen_bit_load_pkg::S_MEMWRLO && cycEnd
    |-> memWrite && memWrData == srcWord[7:0]
    ##1 memWrite && memAddr == $past(memAddr) + 16'h1 && memWrData == $past(srcWord[15:8]);
  endproperty
  a_store_order: assert property (p_store_order) else $error("store byte order wrong");

  property p_sp_copy;
    state_r == sixteen_bit_load_pkg::S_SPCOPY && cycEnd
    |-> tSince_r == 5'(sixteen_bit_load_pkg::TS_SP_COPY - 1)
    ##1 stackPointer == $past(pointerPair) && $stable(pointerPair);
  endproperty
  a_sp_copy: assert property (p_sp_copy) else $error("stack pointer copy wrong");

  property p_flags_stable;
    ##1 $stable(flags);
  endproperty
  a_flags_stable: assert property (p_flags_stable) else $error("flags changed");

  c_imm_pair:  cover property (opDone && kind_r == sixteen_bit_load_pkg::K_IMM && !prefIdx_r);
  c_idx_store: cover property (opDone && kind_r == sixteen_bit_load_pkg::K_STMEM && prefIdx_r);
  c_sp_copy:   cover property (opDone && kind_r == sixteen_bit_load_pkg::K_SPHL);

endmodule // sixteen_bit_load_group

// [design/sixteen_bit_load_pkg.sv]
// Constants and types shared by the 16-bit load group sequencer.
// Assumes one clock, with one clock cycle standing for one T state.
package sixteen_bit_load_pkg;

  // Opcode and prefix bytes
  localparam logic [7:0] OP_PREFIX_IDX1  = 8'hdd;
  localparam logic [7:0] OP_PREFIX_IDX2  = 8'hfd;
  localparam logic [7:0] OP_PREFIX_EXT   = 8'hed;
  localparam logic [7:0] OP_IMM_INDEX    = 8'h21;
  localparam logic [7:0] OP_LOAD_PTR     = 8'h2a;
  localparam logic [7:0] OP_STORE_PTR    = 8'h22;
  localparam logic [7:0] OP_SP_FROM_PTR  = 8'hf9;
  localparam logic [7:0] MASK_PAIR_OP    = 8'hcf;
  localparam logic [7:0] OP_IMM_PAIR     = 8'h01;
  localparam logic [7:0] OP_STORE_PAIR   = 8'h43;
  localparam int         PAIR_FIELD_MSB  = 5;
  localparam int         PAIR_FIELD_LSB  = 4;

  // Register file slots
  localparam int         NUM_REGS            = 6;
  localparam logic [2:0] REG_FIRST_GENERAL   = 3'h0;
  localparam logic [2:0] REG_SECOND_GENERAL  = 3'h1;
  localparam logic [2:0] REG_POINTER         = 3'h2;
  localparam logic [2:0] REG_STACK           = 3'h3;
  localparam logic [2:0] REG_INDEX_FIRST     = 3'h4;
  localparam logic [2:0] REG_INDEX_SECOND    = 3'h5;

  // Machine cycle lengths in T states
  localparam logic [2:0] T_FETCH     = 3'h4;
  localparam logic [2:0] T_MEM       = 3'h3;
  localparam logic [2:0] T_INTERNAL  = 3'h4;
  localparam logic [2:0] T_SP_COPY   = 3'h2;

  // Whole instruction lengths in T states
  localparam int TS_IMM_PAIR   = 10;
  localparam int TS_IMM_INDEX  = 14;
  localparam int TS_LOAD_PTR   = 16;
  localparam int TS_LOAD_INDEX = 20;
  localparam int TS_STORE      = 20;
  localparam int TS_SP_COPY    = 6;

  // Reset values
  localparam logic [15:0] RESET_PC    = 16'h0000;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  localparam logic [7:0]  RESET_FLAGS = 8'h00;

  typedef enum {S_FETCH, S_FETCH2, S_INTERNAL, S_RDLO, S_RDHI, S_MEMRDLO, S_MEMRDHI,
                S_MEMWRLO, S_MEMWRHI, S_SPCOPY} cycle_t;
  typedef enum {K_NONE, K_IMM, K_LDMEM, K_STMEM, K_SPHL} kind_t;

endpackage

// [sim/mem_model.sv]
// Byte-wide memory that answers the load group sequencer on the shared clock.
// Assumes zero wait states: read data follows memAddr while memRead is high.
`timescale 1ns/1ns
module mem_model (
  input  wire logic        clock,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRead,
  input  wire logic        memWrite,
  input  wire logic [7:0]  memWrData,
  output logic      [7:0]  memRdData
);
  logic [7:0] m [0:65535];
  logic [7:0] lastRd_r;

  initial begin
    lastRd_r = 8'h00;
    for (int i = 0; i < 65536; i++) m[i] = 8'h00;
  end

  // Outside a read the bus shows the inverse of the last byte, so stale data never passes
  assign memRdData = memRead ? m[memAddr] : ~lastRd_r;

  always @(posedge clock) begin
    if (memRead) lastRd_r <= m[memAddr];
    if (memWrite) m[memAddr] <= memWrData;
  end
endmodule // mem_model

// [sim/tb_top.sv]
// Self-checking bench for the 16-bit load group sequencer.
// Assumes the memory model holds the program; one straight program runs all scenarios.
`timescale 1ns/1ns
module tb_top;
  logic        clock;
  logic        resetn;
  logic [15:0] memAddr;
  logic        memRead;
  logic        memWrite;
  logic [7:0]  memWrData;
  logic [7:0]  memRdData;
  logic        instrDone;
  logic [15:0] firstGeneralPair;
  logic [15:0] secondGeneralPair;
  logic [15:0] pointerPair;
  logic [15:0] stackPointer;
  logic [15:0] indexRegisterFirst;
  logic [15:0] indexRegisterSecond;
  logic [15:0] programCounter;
  logic [7:0]  flags;
  int          n_fail;
  int          n_checks;
  logic [15:0] wp;
  int          firstT;

  sixteen_bit_load_group uut (.clock(clock), .resetn(resetn), .memAddr(memAddr), .memRead(memRead),
    .memWrite(memWrite), .memWrData(memWrData), .memRdData(memRdData), .instrDone(instrDone),
    .firstGeneralPair(firstGeneralPair), .secondGeneralPair(secondGeneralPair),
    .pointerPair(pointerPair), .stackPointer(stackPointer), .indexRegisterFirst(indexRegisterFirst),
    .indexRegisterSecond(indexRegisterSecond), .programCounter(programCounter), .flags(flags));

  mem_model mem (.clock(clock), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
    .memWrData(memWrData), .memRdData(memRdData));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task finish_test;
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task chk_count(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_fail++;
      $display("[ERR] %0t instruction length %0d expected %0d", $time, got, exp);
    end
  endtask

  // Emit n bytes of w, most significant first, at the write pointer
  task emit(input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      mem.m[wp] = w[31-8*i -: 8];
      wp = wp + 16'h0001;
    end
  endtask

  // Counts T states to the done pulse, then lets the retiring edge land
  task run_instr(input int expT);
    int cnt;
    cnt = firstT;
    firstT = 0;
    do begin
      @(negedge clock);
      cnt++;
      chk8(flags, 8'h00, "flags");
    end while (instrDone !== 1'b1 && cnt < 64);
    if (instrDone !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t no done pulse", $time);
      finish_test();
    end
    chk_count(cnt, expT);
    @(posedge clock);
    #1;
  endtask

  task scn_immediate;
    run_instr(10);
    chk16(firstGeneralPair, 16'h1234, "first pair");
    run_instr(10);
    chk16(secondGeneralPair, 16'h5678, "second pair");
    run_instr(10);
    chk16(pointerPair, 16'h9abc, "pointer pair");
    run_instr(10);
    chk16(stackPointer, 16'hdef0, "stack pointer");
    run_instr(14);
    chk16(indexRegisterFirst, 16'h45a2, "index first");
    run_instr(14);
    chk16(indexRegisterSecond, 16'h7733, "index second");
  endtask

  task scn_load_mem;
    run_instr(16);
    chk16(pointerPair, 16'ha137, "pointer load");
    run_instr(20);
    chk16(indexRegisterFirst, 16'hda92, "index first load");
    run_instr(20);
    chk16(indexRegisterSecond, 16'h5a30, "index second load");
  endtask

  // Stores: 22, ED 43/53/63/73, DD 22, FD 22; the stack pointer store wraps past ffff
  task scn_store;
    logic [15:0] w [7];
    logic [15:0] a [7];
    w = '{16'ha137, 16'h1234, 16'h5678, 16'ha137, 16'hdef0, 16'hda92, 16'h5a30};
    a = '{16'h4010, 16'h4012, 16'h4014, 16'h4016, 16'hffff, 16'h401a, 16'h401c};
    for (int i = 0; i < 7; i++) begin
      run_instr(20);
      chk8(mem.m[a[i]], w[i][7:0], "low byte");
      chk8(mem.m[a[i] + 16'h0001], w[i][15:8], "high byte");
    end
  endtask

  // Unknown opcodes retire as no-ops: 4 T plain, 8 T behind a prefix, nothing written
  task scn_refused;
    run_instr(4);
    chk16(programCounter, 16'h003b, "no-op pointer");
    run_instr(8);
    chk16(programCounter, 16'h003d, "prefixed no-op pointer");
    chk16(indexRegisterFirst, 16'hda92, "index first kept");
  endtask

  task scn_sp_copy;
    run_instr(6);
    chk16(stackPointer, 16'ha137, "stack copy");
    chk16(pointerPair, 16'ha137, "pointer kept");
    chk16(programCounter, 16'h003e, "fetch pointer");
  endtask

  initial begin
    resetn = 1'b0;
    n_fail = 0;
    n_checks = 0;
    wp = 16'h0000;
    #1;
    emit(32'h01341200, 3);
    emit(32'h11785600, 3);
    emit(32'h21bc9a00, 3);
    emit(32'h31f0de00, 3);
    emit(32'hdd21a245, 4);
    emit(32'hfd213377, 4);
    emit(32'h2a004000, 3);
    emit(32'hdd2a0240, 4);
    emit(32'hfd2a0440, 4);
    emit(32'h22104000, 3);
    emit(32'hed431240, 4);
    emit(32'hed531440, 4);
    emit(32'hed631640, 4);
    emit(32'hed73ffff, 4);
    emit(32'hdd221a40, 4);
    emit(32'hfd221c40, 4);
    emit(32'h00dd00f9, 4);
    wp = 16'h4000;
    emit(32'h37a192da, 4);
    emit(32'h305a0000, 2);
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    // Released at a falling edge: the half cycle up to the next rising edge is the first T state
    firstT = 1;
    scn_immediate();
    scn_load_mem();
    scn_store();
    scn_refused();
    scn_sp_copy();
    finish_test();
  end
endmodule // tb_top
